// file: rtl/isa_dma_defs.vh
// register map, field positions and timing counts for the isa dma block
`ifndef ISA_DMA_DEFS_VH
`define ISA_DMA_DEFS_VH

// apb byte offsets
`define REG_CTRL      12'h000
`define REG_STAT      12'h004
`define REG_NCH_BASE  12'h040
`define REG_WCH_BASE  12'h080
`define REG_PAGE_BASE 12'h100
`define REG_PAGE_END  12'h13C

// control register fields
`define CTRL_NREQ_POL 0
`define CTRL_NACK_POL 1
`define CTRL_WREQ_POL 2
`define CTRL_WACK_POL 3
`define CTRL_DLY_LSB  4
`define CTRL_DLY_MSB  6
`define CTRL_SA_EN    7
`define CTRL_RST      8'h10

// channel register fields
`define FLD_ADDR 2'h0
`define FLD_CNT  2'h1
`define FLD_MODE 2'h2
`define MODE_TOMEM 0
`define MODE_CASC  1
`define MODE_EN    2

// page ram
`define PAGE_WORDS 16
`define PAGE_REFRESH_LOC 4'h4

// command timing, in dma clocks
`define CMD_CYC      4'h3
`define WR_LEAD_CYC  4'h1

`endif

// file: rtl/dma_ctrl.v
// four-channel dma controller core: arbitration, address and count
`timescale 1ns/1ps
`include "isa_dma_defs.vh"
module dma_ctrl (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire [3:0]  req_i,
	output wire [3:0]  ack_o,
	output wire        hold_o,
	input  wire        hlda_i,
	input  wire        done_i,
	output wire        busy_o,
	output wire [1:0]  sel_o,
	output wire [15:0] addr_o,
	output wire        last_o,
	output wire        tomem_o,
	input  wire        wr_i,
	input  wire [1:0]  wr_ch_i,
	input  wire [1:0]  wr_fld_i,
	input  wire [15:0] wdata_i,
	input  wire [1:0]  rd_ch_i,
	output wire [15:0] rd_addr_o,
	output wire [15:0] rd_cnt_o,
	output wire [2:0]  rd_mode_o
);
	localparam S_IDLE  = 2'd0;
	localparam S_HOLD  = 2'd1;
	localparam S_GRANT = 2'd2;

	reg [15:0] cur_addr_r [0:3];
	reg [15:0] cur_cnt_r  [0:3];
	reg [2:0]  mode_r     [0:3];
	reg [1:0]  state_r;
	reg [1:0]  sel_r;
	wire [3:0] act;
	wire       casc;
	integer    i;

	// fixed priority, lowest channel first
	function [1:0] pick;
		input [3:0] v;
		begin
			pick = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : en
			assign act[g] = req_i[g] & mode_r[g][`MODE_EN];
		end
	endgenerate

	assign casc      = mode_r[sel_r][`MODE_CASC];
	assign hold_o    = (state_r != S_IDLE);
	assign ack_o     = (state_r == S_GRANT) ? (4'b0001 << sel_r) : 4'b0000;
	assign busy_o    = (state_r == S_GRANT) & ~casc;
	assign sel_o     = sel_r;
	assign addr_o    = cur_addr_r[sel_r];
	assign last_o    = (cur_cnt_r[sel_r] == 16'h0000);
	assign tomem_o   = mode_r[sel_r][`MODE_TOMEM];
	assign rd_addr_o = cur_addr_r[rd_ch_i];
	assign rd_cnt_o  = cur_cnt_r[rd_ch_i];
	assign rd_mode_o = mode_r[rd_ch_i];

	// channel registers; only the 16-bit counter moves, the page never does
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (i = 0; i < 4; i = i + 1) begin
				cur_addr_r[i] <= 16'h0000;
				cur_cnt_r[i]  <= 16'h0000;
				mode_r[i]     <= 3'h0;
			end
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				if (wr_i && wr_ch_i == i[1:0]) begin
					if (wr_fld_i == `FLD_ADDR)
						cur_addr_r[i] <= wdata_i;
					if (wr_fld_i == `FLD_CNT)
						cur_cnt_r[i] <= wdata_i;
					if (wr_fld_i == `FLD_MODE)
						mode_r[i] <= wdata_i[2:0];
				end else if (done_i && sel_r == i[1:0]) begin
					cur_addr_r[i] <= cur_addr_r[i] + 16'h0001;
					cur_cnt_r[i]  <= cur_cnt_r[i] - 16'h0001;
					if (cur_cnt_r[i] == 16'h0000)
						mode_r[i][`MODE_EN] <= 1'b0; // block done, channel masks itself
				end
			end
		end
	end

	// hold/hlda handshake and grant; one transfer per grant
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= S_IDLE;
			sel_r   <= 2'd0;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (|act) begin
						sel_r   <= pick(act);
						state_r <= S_HOLD;
					end
				end
				S_HOLD: begin
					if (!act[sel_r])
						state_r <= S_IDLE;
					else if (hlda_i)
						state_r <= S_GRANT;
				end
				S_GRANT: begin
					if (casc ? !req_i[sel_r] : done_i)
						state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule

// file: rtl/isa_dma_bus_control.v
// isa command direction control with cascaded narrow/wide fly-by dma
`timescale 1ns/1ps
`include "isa_dma_defs.vh"
//
// Contract
// - aen high only during own dma cycles
// - external master ownership forces aen low
// - memory strobes driven only in dma/refresh
// - system strobes copy memory strobes below 1m
// - refresh makes system read copy read
// - io strobes driven only during dma
// - requests input; acks and tc always driven
// - wide increment advances two bytes
// - channels 0-3 byte, 5-7 word
// - counter wraps inside 64k/128k window
// - wide registers decode every other port
// - request/ack polarity programmable per controller
// - narrow hold cascades into wide channel zero
// - cascade ack until request drops, no drive
// - sixteen-entry page ram, bit0 ignored wide
// - upper bits from page of active channel
// - fly-by: ior+memw write, memr+iow read
// - write: ior one clock before memw
// - read: memr delayed by programmable count
// - link strobe hands a10-a16 to companion
// - device drives sa0-7, a8-9, a17-23
module isa_dma_bus_control (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	input  wire [7:0]  dreq_i,
	output wire [7:0]  dack_o,
	output wire        tc_o,
	output wire        hold_o,
	input  wire        hlda_i,
	input  wire        master_n_i,
	input  wire        refresh_n_i,
	input  wire        refresh_memr_n_i,
	input  wire [3:0]  bus_a_hi_i,
	input  wire        memr_n_i,
	output wire        memr_n_o,
	output wire        memr_oe_n_o,
	input  wire        memw_n_i,
	output wire        memw_n_o,
	output wire        memw_oe_n_o,
	input  wire        ior_n_i,
	output wire        ior_n_o,
	output wire        ior_oe_n_o,
	input  wire        iow_n_i,
	output wire        iow_n_o,
	output wire        iow_oe_n_o,
	output wire        smemr_n_o,
	output wire        smemw_n_o,
	output wire        aen_o,
	output wire [7:0]  sa_o,
	output wire [1:0]  a89_o,
	output wire [6:0]  a_hi_o,
	output wire        addr_oe_n_o,
	output wire [2:0]  sa1719_o,
	output wire        sa1719_oe_n_o,
	output wire        link_output_strobe_o,
	output wire [7:0]  peripheral_data_bus_o,
	output wire        peripheral_data_bus_oe_n_o
);
	localparam S_IDLE  = 3'd0;
	localparam S_LINK  = 3'd1;
	localparam S_SETUP = 3'd2;
	localparam S_CMD   = 3'd3;
	localparam S_END   = 3'd4;
	localparam K_NONE  = 3'd0;
	localparam K_CTRL  = 3'd1;
	localparam K_STAT  = 3'd2;
	localparam K_NCH   = 3'd3;
	localparam K_WCH   = 3'd4;
	localparam K_PAGE  = 3'd5;

	reg [7:0]  ctrl_r;
	reg [7:0]  page_r [0:`PAGE_WORDS-1];
	reg [7:0]  tc_flag_r;
	reg [2:0]  state_r;
	reg [3:0]  cnt_r;
	reg [23:0] addr_r;
	reg [2:0]  ch_r;
	reg        tomem_r;
	reg        last_r;
	integer    i;

	wire [3:0]  n_req, w_req, n_ack, w_ack;
	wire        n_hold, n_busy, w_busy, n_last, w_last, n_tomem, w_tomem;
	wire [1:0]  n_sel, w_sel;
	wire [15:0] n_addr, w_addr, n_rd_addr, w_rd_addr, n_rd_cnt, w_rd_cnt;
	wire [2:0]  n_rd_mode, w_rd_mode;

	// register decode, shared by the read and write paths
	function [2:0] kind;
		input [11:0] a;
		begin
			if (a[1:0] != 2'b00)
				kind = K_NONE;
			else if (a == `REG_CTRL)
				kind = K_CTRL;
			else if (a == `REG_STAT)
				kind = K_STAT;
			else if (a >= `REG_NCH_BASE && a < `REG_WCH_BASE)
				kind = (a[3:2] != 2'b11) ? K_NCH : K_NONE;
			else if (a >= `REG_WCH_BASE && a < `REG_PAGE_BASE)
				kind = (!a[2] && a[4:3] != 2'b11) ? K_WCH : K_NONE;
			else if (a >= `REG_PAGE_BASE && a <= `REG_PAGE_END)
				kind = K_PAGE;
			else
				kind = K_NONE;
		end
	endfunction

	wire [2:0]  k      = kind(paddr_i);
	wire        wr_acc = psel_i & penable_i & pwrite_i;
	wire        rd_acc = psel_i & penable_i & ~pwrite_i;
	// narrow field at word stride, wide field at every other word
	wire [1:0]  n_ch   = paddr_i[5:4];
	wire [1:0]  n_fld  = paddr_i[3:2];
	wire [1:0]  w_ch   = paddr_i[6:5];
	wire [1:0]  w_fld  = paddr_i[4:3];
	wire [3:0]  pg_idx = paddr_i[5:2];

	// zero-wait slave; bad offsets answer with an error
	assign pready_o  = psel_i & penable_i;
	assign pslverr_o = psel_i & penable_i & (k == K_NONE);

	// read data registered in the setup phase, stable through access
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			case (k)
				K_CTRL:  prdata_o <= {24'h00_0000, ctrl_r};
				K_STAT:  prdata_o <= {14'h0000, w_busy | n_busy, hold_o,
					w_ack[3:1], w_ack[0], n_ack, tc_flag_r};
				K_NCH: begin
					if (n_fld == `FLD_MODE)
						prdata_o <= {29'h0000_0000, n_rd_mode};
					else
						prdata_o <= {16'h0000, n_fld[0] ? n_rd_cnt : n_rd_addr};
				end
				K_WCH: begin
					if (w_fld == `FLD_MODE)
						prdata_o <= {29'h0000_0000, w_rd_mode};
					else
						prdata_o <= {16'h0000, w_fld[0] ? w_rd_cnt : w_rd_addr};
				end
				K_PAGE:  prdata_o <= {24'h00_0000, page_r[pg_idx]};
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// control register and page ram write port
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_r <= `CTRL_RST;
			for (i = 0; i < `PAGE_WORDS; i = i + 1)
				page_r[i] <= 8'h00;
		end else if (wr_acc) begin
			if (k == K_CTRL)
				ctrl_r <= pwdata_i[7:0];
			if (k == K_PAGE)
				page_r[pg_idx] <= pwdata_i[7:0];
		end
	end

	// pin polarity per controller; compatible setting is all zeros
	assign n_req = dreq_i[3:0] ^ {4{ctrl_r[`CTRL_NREQ_POL]}};
	assign w_req = {dreq_i[7:5] ^ {3{ctrl_r[`CTRL_WREQ_POL]}}, n_hold};
	assign dack_o[3:0] = ~n_ack ^ {4{ctrl_r[`CTRL_NACK_POL]}};
	assign dack_o[7:5] = ~w_ack[3:1] ^ {3{ctrl_r[`CTRL_WACK_POL]}};
	// channel four is internal, its pin parks inactive
	assign dack_o[4]   = ~ctrl_r[`CTRL_WACK_POL];

	// byte controller: channels 0-3, hold goes to wide channel zero
	dma_ctrl u_narrow (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.req_i     (n_req),
		.ack_o     (n_ack),
		.hold_o    (n_hold),
		.hlda_i    (w_ack[0]),
		.done_i    (state_r == S_END && !ch_r[2]),
		.busy_o    (n_busy),
		.sel_o     (n_sel),
		.addr_o    (n_addr),
		.last_o    (n_last),
		.tomem_o   (n_tomem),
		.wr_i      (wr_acc && k == K_NCH),
		.wr_ch_i   (n_ch),
		.wr_fld_i  (n_fld),
		.wdata_i   (pwdata_i[15:0]),
		.rd_ch_i   (n_ch),
		.rd_addr_o (n_rd_addr),
		.rd_cnt_o  (n_rd_cnt),
		.rd_mode_o (n_rd_mode)
	);

	// word controller: channels 4-7, owns the external hold pair
	dma_ctrl u_wide (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.req_i     (w_req),
		.ack_o     (w_ack),
		.hold_o    (hold_o),
		.hlda_i    (hlda_i),
		.done_i    (state_r == S_END && ch_r[2]),
		.busy_o    (w_busy),
		.sel_o     (w_sel),
		.addr_o    (w_addr),
		.last_o    (w_last),
		.tomem_o   (w_tomem),
		.wr_i      (wr_acc && k == K_WCH),
		.wr_ch_i   (w_ch),
		.wr_fld_i  (w_fld),
		.wdata_i   (pwdata_i[15:0]),
		.rd_ch_i   (w_ch),
		.rd_addr_o (w_rd_addr),
		.rd_cnt_o  (w_rd_cnt),
		.rd_mode_o (w_rd_mode)
	);

	// the narrow side only runs while the wide cascade grants it
	wire        use_n = n_busy;
	wire [2:0]  sel_ch = use_n ? {1'b0, n_sel} : {1'b1, w_sel};
	wire [7:0]  page = page_r[{1'b0, sel_ch}];
	// byte: direct map; word: shifted, a0 forced low, page bit0 dropped
	wire [23:0] sys_addr = use_n ? {page, n_addr}
		: {page[7:1], w_addr, 1'b0};
	// write leads by one clock; read waits the programmed delay
	wire [3:0]  dly = tomem_r ? `WR_LEAD_CYC
		: {1'b0, ctrl_r[`CTRL_DLY_MSB:`CTRL_DLY_LSB]};
	wire [3:0]  cmd_end = dly + `CMD_CYC - 4'h1;

	// transfer sequencer: link strobe, address setup, command, release
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= S_IDLE;
			cnt_r   <= 4'h0;
			addr_r  <= 24'h00_0000;
			ch_r    <= 3'd0;
			tomem_r <= 1'b0;
			last_r  <= 1'b0;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (n_busy | w_busy) begin
						addr_r  <= sys_addr;
						ch_r    <= sel_ch;
						tomem_r <= use_n ? n_tomem : w_tomem;
						last_r  <= use_n ? n_last : w_last;
						state_r <= S_LINK;
					end
				end
				S_LINK:  state_r <= S_SETUP;
				S_SETUP: begin
					cnt_r   <= 4'h0;
					state_r <= S_CMD;
				end
				S_CMD: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r >= cmd_end)
						state_r <= S_END;
				end
				S_END:   state_r <= S_IDLE;
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// sticky completion flags; a status read clears only the bits it returned,
	// so a flag set between setup and access is not lost; a new set wins
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			tc_flag_r <= 8'h00;
		else
			tc_flag_r <= (tc_flag_r & ~((rd_acc && k == K_STAT) ? prdata_o[7:0] : 8'h00))
				| ((state_r == S_END && last_r) ? (8'h01 << ch_r) : 8'h00);
	end

	wire dma  = (state_r != S_IDLE); // own cycle, cascade excluded
	wire cmd  = (state_r == S_CMD);
	wire ior_a  = cmd & tomem_r;
	wire memw_a = cmd & tomem_r & (cnt_r >= `WR_LEAD_CYC);
	wire iow_a  = cmd & ~tomem_r;
	wire memr_a = cmd & ~tomem_r & (cnt_r >= dly);

	assign aen_o = dma & master_n_i;
	assign tc_o  = cmd & last_r;

	// command pins: driven in own dma, read strobe also in refresh
	assign memr_n_o    = dma ? ~memr_a : refresh_memr_n_i;
	assign memr_oe_n_o = ~(dma | ~refresh_n_i);
	assign memw_n_o    = ~memw_a;
	assign memw_oe_n_o = ~dma;
	assign ior_n_o     = ~ior_a;
	assign ior_oe_n_o  = ~dma;
	assign iow_n_o     = ~iow_a;
	assign iow_oe_n_o  = ~dma;

	// below-1m strobes follow the wire level, whoever drives it
	wire memr_lvl = memr_oe_n_o ? memr_n_i : memr_n_o;
	wire memw_lvl = memw_oe_n_o ? memw_n_i : memw_n_o;
	wire [3:0] hi = dma ? addr_r[23:20] : bus_a_hi_i;
	wire below_1m = (hi == 4'h0);
	assign smemr_n_o = (below_1m | ~refresh_n_i) ? memr_lvl : 1'b1;
	assign smemw_n_o = below_1m ? memw_lvl : 1'b1;

	// address pins; a10-a16 leave through the link strobe instead
	assign sa_o        = addr_r[7:0];
	assign a89_o       = addr_r[9:8];
	assign a_hi_o      = addr_r[23:17];
	assign addr_oe_n_o = ~dma;
	assign sa1719_o    = addr_r[19:17];
	assign sa1719_oe_n_o = ~(dma & ctrl_r[`CTRL_SA_EN]);
	assign link_output_strobe_o = (state_r == S_LINK);
	assign peripheral_data_bus_o = {1'b0, addr_r[16:10]};
	// held through setup so the companion latch has hold time
	assign peripheral_data_bus_oe_n_o = ~(state_r == S_LINK || state_r == S_SETUP);
endmodule

// file: verification/isa_dma_chk_sva.sv
// concurrent checks on the isa dma block pins
`timescale 1ns/1ps
module isa_dma_chk (
	input logic       clk_i,
	input logic       resetn_i,
	input logic       hlda_i,
	input logic       master_n_i,
	input logic       refresh_n_i,
	input logic [3:0] bus_a_hi_i,
	input logic       memr_n_i,
	input logic       memw_n_i,
	input logic       memw_n_o,
	input logic       memw_oe_n_o,
	input logic       ior_n_o,
	input logic       ior_oe_n_o,
	input logic       iow_oe_n_o,
	input logic       smemr_n_o,
	input logic       smemw_n_o,
	input logic       aen_o,
	input logic [7:0] sa_o,
	input logic [7:0] dack_o,
	input logic       tc_o,
	input logic       addr_oe_n_o,
	input logic       link_output_strobe_o,
	input logic [7:0] peripheral_data_bus_o,
	input logic       peripheral_data_bus_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// aen belongs to granted dma only
	aen_grant_a: assert property (aen_o |-> hlda_i) else $error("aen outside grant");
	aen_master_a: assert property (!master_n_i |-> !aen_o) else $error("aen under master");
	aen_link_a: assert property ($rose(aen_o) |-> link_output_strobe_o) else $error("aen without link");
	// strobe direction follows cycle kind
	memw_drive_a: assert property (!memw_oe_n_o |-> aen_o) else $error("memw driven outside dma");
	io_drive_a: assert property (!ior_oe_n_o || !iow_oe_n_o |-> aen_o) else $error("io strobe driven");
	// system strobes; address only known when released
	smem_high_a: assert property (addr_oe_n_o && |bus_a_hi_i && refresh_n_i |-> smemr_n_o && smemw_n_o)
		else $error("system strobe above 1m");
	smem_copy_a: assert property (addr_oe_n_o && bus_a_hi_i == 4'h0 |-> smemw_n_o == memw_n_i)
		else $error("system write not copied");
	refresh_copy_a: assert property (!refresh_n_i |-> smemr_n_o == memr_n_i) else $error("refresh read");
	// extended write: io read leads memory write by one clock
	ior_lead_a: assert property ($fell(ior_n_o) && !ior_oe_n_o && !memw_oe_n_o |=> $fell(memw_n_o))
		else $error("write lead wrong");
	link_pulse_a: assert property (link_output_strobe_o |-> !peripheral_data_bus_oe_n_o ##1 !link_output_strobe_o)
		else $error("link strobe shape");
	wide_a0_a: assert property (aen_o && dack_o[7:5] != 3'h7 |-> !sa_o[0]) else $error("wide a0 set");
	tc_cmd_a: assert property (tc_o |-> aen_o && !link_output_strobe_o) else $error("tc outside command");
	cover property (link_output_strobe_o);
	cover property (!refresh_n_i && !smemr_n_o);
	cover property (tc_o);
endmodule

bind isa_dma_bus_control isa_dma_chk chk_u (.clk_i, .resetn_i, .hlda_i, .master_n_i, .refresh_n_i, .bus_a_hi_i,
	.memr_n_i, .memw_n_i, .memw_n_o, .memw_oe_n_o, .ior_n_o, .ior_oe_n_o, .iow_oe_n_o, .smemr_n_o, .smemw_n_o,
	.aen_o, .sa_o, .dack_o, .tc_o, .addr_oe_n_o, .link_output_strobe_o, .peripheral_data_bus_o,
	.peripheral_data_bus_oe_n_o);

// file: verification/isa_far.sv
// far side of the isa bus: arbiter grant and pulled-up strobe wires
`timescale 1ns/1ps
module isa_far (
	input  logic       clk_i,
	input  logic       resetn_i,
	input  logic       hold_i,
	input  logic [3:0] dly_i,
	input  logic [3:0] drv_n_i,
	input  logic [3:0] oe_n_i,
	input  logic [3:0] ext_n_i,
	output logic       hlda_o,
	output logic [3:0] bus_n_o
);
	logic [3:0] cnt_r;
	// grant after a chosen wait, held until hold drops
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r  <= 4'h0;
			hlda_o <= 1'b0;
		end else if (!hold_i) begin
			cnt_r  <= 4'h0;
			hlda_o <= 1'b0;
		end else if (cnt_r >= dly_i) begin
			hlda_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	// wired low wins; a released wire floats up to the pull-up
	assign bus_n_o = (drv_n_i | oe_n_i) & ext_n_i;
endmodule

// file: verification/tb.sv
// self-checking bench for the isa dma block
`timescale 1ns/1ps
`include "isa_dma_defs.vh"
module tb;
	logic        clk_i = 0;
	logic        resetn_i = 0;
	logic        psel = 0, penable = 0, pwrite = 0, rd_e;
	logic        master_n = 1, refresh_n = 1, rf_memr_n = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd_d;
	logic [7:0]  dreq = 0, dack, sa, pd;
	logic [3:0]  a_hi_in = 0, ext_n = 4'hF, gdly = 4'h1;
	logic [1:0]  a89;
	logic [6:0]  a_hi;
	logic [2:0]  s19;
	logic        s19_oe_n;
	logic        pready, pslverr, tc, hold, hlda, smemr_n, smemw_n, aen, a_oe_n, lstb, pd_oe_n;
	wire  [3:0]  drv_n, oe_n, bus_n;
	int          bad_count = 0, tests_run = 0, cyc = 0, i;

	isa_dma_bus_control uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.dreq_i(dreq), .dack_o(dack), .tc_o(tc), .hold_o(hold), .hlda_i(hlda), .master_n_i(master_n),
		.refresh_n_i(refresh_n), .refresh_memr_n_i(rf_memr_n), .bus_a_hi_i(a_hi_in),
		.memr_n_i(bus_n[0]), .memr_n_o(drv_n[0]), .memr_oe_n_o(oe_n[0]),
		.memw_n_i(bus_n[1]), .memw_n_o(drv_n[1]), .memw_oe_n_o(oe_n[1]),
		.ior_n_i(bus_n[2]), .ior_n_o(drv_n[2]), .ior_oe_n_o(oe_n[2]),
		.iow_n_i(bus_n[3]), .iow_n_o(drv_n[3]), .iow_oe_n_o(oe_n[3]),
		.smemr_n_o(smemr_n), .smemw_n_o(smemw_n), .aen_o(aen), .sa_o(sa), .a89_o(a89), .a_hi_o(a_hi),
		.addr_oe_n_o(a_oe_n), .sa1719_o(s19), .sa1719_oe_n_o(s19_oe_n), .link_output_strobe_o(lstb),
		.peripheral_data_bus_o(pd), .peripheral_data_bus_oe_n_o(pd_oe_n));
	isa_far far_u (.clk_i(clk_i), .resetn_i(resetn_i), .hold_i(hold), .dly_i(gdly), .drv_n_i(drv_n),
		.oe_n_i(oe_n), .ext_n_i(ext_n), .hlda_o(hlda), .bus_n_o(bus_n));

	always #2 clk_i = ~clk_i;
	// hang guard, far above the ~140 cycles needed
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict;
		end
	end

	task print_verdict;
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one apb transfer; held until pready is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		rd_d = prdata;
		rd_e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic er);
		apb(0, a, 0);
		chk({rd_e, rd_d}, {er, e});
	endtask
	// follow one fly-by transfer from link strobe to end of aen
	task automatic xfer(input logic [23:0] adr, input logic rdx, input int dif, input logic t, input logic se);
		int n1;
		int n2;
		logic tcs;
		n1 = 0;
		n2 = 0;
		tcs = 0;
		for (i = 0; i < 80 && lstb !== 1'b1; i++) @(posedge clk_i) #1;
		chk(lstb, 1);
		chk({pd, a_hi, a89, sa}, {1'b0, adr[16:10], adr[23:17], adr[9:0]});
		chk({s19_oe_n, s19}, {!se, adr[19:17]});
		for (i = 0; i < 80 && aen === 1'b1; i++) begin
			n1 += !bus_n[rdx ? 3 : 2];
			n2 += !bus_n[rdx ? 0 : 1];
			tcs |= tc;
			@(posedge clk_i) #1;
		end
		chk(n1 - n2, dif);
		chk(n2 > 0, 1);
		chk(tcs, t);
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		resetn_i <= 1;
		rd(`REG_CTRL, 32'h0000_0010, 0);
		rd(`REG_NCH_BASE + 12'h00C, 32'h0000_0000, 1);
		rd(`REG_WCH_BASE + 12'h004, 32'h0000_0000, 1);
		wr(`REG_CTRL, 32'h0000_001A);
		#1 chk({dack[7:5], dack[3:0]}, 32'h0000_0000);
		wr(`REG_CTRL, 32'h0000_0010);
		$display("test map done");
		// narrow channel 1 to memory, two transfers across a window wrap
		wr(`REG_WCH_BASE + 12'h010, 32'h0000_0006);
		rd(`REG_WCH_BASE + 12'h010, 32'h0000_0006, 0);
		wr(`REG_PAGE_BASE + 12'h004, 32'h0000_0012);
		wr(`REG_NCH_BASE + 12'h010, 32'h0000_FFFF);
		wr(`REG_NCH_BASE + 12'h014, 32'h0000_0001);
		wr(`REG_NCH_BASE + 12'h018, 32'h0000_0005);
		dreq[1] <= 1;
		xfer(24'h12_FFFF, 0, 1, 0, 0);
		xfer(24'h12_0000, 0, 1, 1, 0);
		@(posedge clk_i);
		dreq[1] <= 0;
		apb(0, `REG_STAT, 0);
		chk(rd_d & 32'h0000_000F, 32'h0000_0002);
		$display("test narrow done");
		// wide channel 5 memory read, slow grant, longer read delay, sa17-19 driven
		wr(`REG_CTRL, 32'h0000_00A0);
		wr(`REG_PAGE_BASE + 12'h014, 32'h0000_0035);
		wr(`REG_WCH_BASE + 12'h020, 32'h0000_0001);
		wr(`REG_WCH_BASE + 12'h028, 32'h0000_0001);
		wr(`REG_WCH_BASE + 12'h030, 32'h0000_0004);
		gdly <= 4'h3;
		dreq[5] <= 1;
		xfer(24'h34_0002, 1, 2, 0, 1);
		xfer(24'h34_0004, 1, 2, 1, 1);
		@(posedge clk_i);
		dreq[5] <= 0;
		$display("test wide done");
		// cascade channel 6 lends the bus to an isa master
		wr(`REG_WCH_BASE + 12'h050, 32'h0000_0006);
		gdly <= 4'h0;
		dreq[6] <= 1;
		for (i = 0; i < 40 && dack[6] !== 1'b0; i++) @(posedge clk_i);
		master_n <= 0;
		ext_n <= 4'hD;
		repeat (5) @(posedge clk_i);
		#1 chk({dack[6], aen, oe_n, a_oe_n, smemw_n}, {1'b0, 1'b0, 4'hF, 1'b1, 1'b0});
		@(posedge clk_i);
		dreq[6] <= 0;
		master_n <= 1;
		ext_n <= 4'hF;
		repeat (4) @(posedge clk_i);
		#1 chk(dack[6], 1);
		$display("test cascade done");
		// refresh above 1m, then a foreign read above 1m
		@(posedge clk_i);
		refresh_n <= 0;
		rf_memr_n <= 0;
		a_hi_in <= 4'hF;
		@(posedge clk_i);
		#1 chk({smemr_n, smemw_n, oe_n}, {1'b0, 1'b1, 4'hE});
		@(posedge clk_i);
		refresh_n <= 1;
		ext_n <= 4'hE;
		@(posedge clk_i);
		#1 chk({smemr_n, oe_n}, {1'b1, 4'hF});
		$display("test refresh done");
		print_verdict;
	end
endmodule
